// file: design/pfta_prog_timer.sv
// Purpose: Internal programming timer for self-timed writes and erases.
// Assumes: start is never raised while busy.
// Notes: done is a one-cycle pulse in the last cycle of busy.
`timescale 1ns/1ps
`default_nettype none
module pfta_prog_timer
	import pfta_pkg::*;
#(
	parameter int unsigned CYCLES = PFTA_PROG_CYCLES
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic start,
	input wire logic abort,
	output logic busy,
	output logic done
);
	localparam int CW = $clog2(CYCLES + 1);

	logic [CW-1:0] cnt_r;

	// Busy while counting, done in the final cycle
	assign busy = (cnt_r != '0);
	assign done = (cnt_r == CW'(1)) && !abort;

	// Down counter loaded at start, cleared by an abort
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r <= '0;
		end else if (abort) begin
			cnt_r <= '0;
		end else if (start) begin
			cnt_r <= CW'(CYCLES);
		end else if (busy) begin
			cnt_r <= cnt_r - CW'(1);
		end
	end
endmodule
`default_nettype wire

// file: design/pfta_top.sv
// Purpose: Table access and self-programming sequencer for program flash.
// Assumes: Register port and table requests are synchronous to core_clk.
// Notes: The array itself sits outside; this block drives its commands.
// How it works
// R1 - Reads take one byte; writes whole 8-byte blocks; erases 64-byte rows.
// R2 - No command exists to bulk erase the whole array.
// R3 - Fetches stall while a self-timed cycle runs; the timer ends it.
// R4 - A fetched word flagged undecodable is executed as a no-operation.
// R5 - Program space and data space exchange bytes through the table latch.
// R6 - Table write puts the latch into holding register chosen by bits 2:0.
// R7 - Programming writes holding registers to block at pointer bits 21:3.
// R8 - Row erase clears the row at bits 21:6; bits 5:0 are ignored.
// R9 - Table read uses all 22 pointer bits to choose the byte.
// R10 - Pointer is upper, high and low bytes; top bit selects config space.
// R11 - Pointer actions: keep, post-increment, post-decrement, pre-increment.
// R12 - Increments and decrements touch the low 21 bits only.
// R13 - Unlock key port has no storage and reads as zero.
// R14 - Config select overrides program select; program select picks flash.
// R15 - Erase enable makes the next start erase, cleared on completion.
// R16 - Cycles start only with write allow set; cleared at power-up.
// R17 - Pin or watchdog reset during a cycle sets abort flag, keeps selects.
// R18 - Write start is set-only by software and cleared at completion.
// R19 - Completion sets the write-done flag until software clears it.
// R20 - Read start pulses one EEPROM read, self-clears, blocked in program.
// R21 - Software places executable words at word-aligned addresses.
// R22 - Start needs 55h then AAh written to the unlock key port first.
// R23 - Each self-timed cycle stalls the processor for about 2 ms.
// R24 - Pointer bit 0 picks the low or high byte of a program word.
// R25 - A start without unlock or write allow is ignored.
`timescale 1ns/1ps
`default_nettype none
module pfta_top
	import pfta_pkg::*;
#(
	parameter int unsigned PROG_CYCLES = PFTA_PROG_CYCLES
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic [PFTA_ADDR_W-1:0] reg_addr,
	input wire logic [PFTA_DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [PFTA_DATA_W-1:0] reg_rdata,
	input wire pfta_tbl_req_t tbl_req,
	output logic tbl_ready,
	output logic fr_en,
	output logic [PFTA_WORD_ADDR_W-1:0] fr_word_addr,
	input wire logic [15:0] fr_rdata,
	output pfta_flash_cmd_t fl_cmd,
	output logic [63:0] fl_wdata,
	output logic fl_busy,
	output logic ee_rd_pulse,
	input wire logic ext_reset_evt,
	input wire logic wdt_reset_evt,
	output logic fetch_stall,
	input wire logic [15:0] fetch_word,
	input wire logic fetch_illegal,
	output logic [15:0] exec_word
);
	// Address match against one register offset
	function automatic logic hit(input logic [PFTA_ADDR_W-1:0] a,
		input logic [PFTA_ADDR_W-1:0] off);
		hit = (a == off);
	endfunction

	// Config select wins over program select
	function automatic pfta_space_t space_of(input logic cfg, input logic pgm);
		if (cfg) begin
			space_of = PFTA_SPACE_CONFIG;
		end else if (pgm) begin
			space_of = PFTA_SPACE_PROGRAM;
		end else begin
			space_of = PFTA_SPACE_EEPROM;
		end
	endfunction

	// Control register fields
	logic pgm_sel_r, cfg_sel_r, erase_en_r, abort_flag_r;
	logic wr_allow_r, wr_start_r, rd_start_r;
	logic done_flag_r;
	logic [7:0] latch_r;
	logic [PFTA_PTR_W-1:0] ptr_r;
	logic [7:0] hold_r [PFTA_HOLD_N];
	pfta_unlock_t unlock_r, unlock_nxt;
	logic op_erase_r;
	logic rd_pend_r, rd_hi_r;
	logic [PFTA_DATA_W-1:0] rdata_r;
	pfta_flash_cmd_t cmd_r;
	logic [63:0] wdata_r;
	logic fr_en_r;
	logic [PFTA_WORD_ADDR_W-1:0] fr_addr_r;
	logic [15:0] exec_r;

	// Register port decode
	logic wr_mac, wr_key, wr_flags, wr_latch, wr_pl, wr_ph, wr_pu;
	assign wr_mac = reg_wr && hit(reg_addr, PFTA_OFF_MAC);
	assign wr_key = reg_wr && hit(reg_addr, PFTA_OFF_KEY);
	assign wr_flags = reg_wr && hit(reg_addr, PFTA_OFF_FLAGS2);
	assign wr_latch = reg_wr && hit(reg_addr, PFTA_OFF_LATCH);
	assign wr_pl = reg_wr && hit(reg_addr, PFTA_OFF_PTR_LOW);
	assign wr_ph = reg_wr && hit(reg_addr, PFTA_OFF_PTR_HIGH);
	assign wr_pu = reg_wr && hit(reg_addr, PFTA_OFF_PTR_UPPER);

	// Reset events that may abort a running cycle
	logic abort_evt, tm_busy, tm_done;
	assign abort_evt = ext_reset_evt || wdt_reset_evt;

	// Start request qualified by the unlock sequence and write allow
	logic start_ok, start_erase;
	pfta_space_t start_space;
	assign start_ok = wr_mac && reg_wdata[PFTA_BIT_WR] && !wr_start_r
		&& (unlock_r == PFTA_UNLK_ARMED) && wr_allow_r
		&& !abort_evt; // [R16] [R22] [R25]
	assign start_space = space_of(reg_wdata[PFTA_BIT_CFG],
		reg_wdata[PFTA_BIT_PGM]); // [R14]
	// Erase only applies to flash rows; there is no whole-array erase
	assign start_erase = reg_wdata[PFTA_BIT_ERASE]
		&& (start_space != PFTA_SPACE_EEPROM); // [R2] [R15]

	// Unlock sequence: 55h, then AAh, then the start; any other write disarms
	always_comb begin
		unlock_nxt = unlock_r;
		if (reg_wr) begin
			if (wr_key && reg_wdata == PFTA_KEY_FIRST) begin
				unlock_nxt = PFTA_UNLK_HALF; // [R22]
			end else if (wr_key && reg_wdata == PFTA_KEY_SECOND
				&& unlock_r == PFTA_UNLK_HALF) begin
				unlock_nxt = PFTA_UNLK_ARMED; // [R22]
			end else begin
				unlock_nxt = PFTA_UNLK_IDLE; // [R25]
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			unlock_r <= PFTA_UNLK_IDLE;
		end else begin
			unlock_r <= unlock_nxt;
		end
	end

	// Programming timer
	pfta_prog_timer #(
		.CYCLES(PROG_CYCLES)
	) u_timer (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.start(start_ok),
		.abort(abort_evt),
		.busy(tm_busy),
		.done(tm_done)
	);

	// Select bits survive an abort so software can see what failed
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pgm_sel_r <= 1'b0;
			cfg_sel_r <= 1'b0;
		end else if (wr_mac && !abort_evt) begin
			pgm_sel_r <= reg_wdata[PFTA_BIT_PGM];
			cfg_sel_r <= reg_wdata[PFTA_BIT_CFG];
		end // [R17]
	end

	// Abort flag: set by a reset event during a cycle, set wins over clear
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			abort_flag_r <= 1'b0;
		end else if (abort_evt && tm_busy) begin
			abort_flag_r <= 1'b1; // [R17]
		end else if (wr_mac) begin
			abort_flag_r <= reg_wdata[PFTA_BIT_ABORT];
		end
	end

	// Write allow, cleared at power-up and by a reset event
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_allow_r <= 1'b0; // [R16]
		end else if (abort_evt) begin
			wr_allow_r <= 1'b0;
		end else if (wr_mac) begin
			wr_allow_r <= reg_wdata[PFTA_BIT_ALLOW];
		end
	end

	// Erase enable: completion of an erase clears it over any write
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			erase_en_r <= 1'b0;
		end else if (abort_evt || (tm_done && op_erase_r)) begin
			erase_en_r <= 1'b0; // [R15]
		end else if (wr_mac) begin
			erase_en_r <= reg_wdata[PFTA_BIT_ERASE];
		end
	end

	// Write start: software can only set it, completion clears it
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_start_r <= 1'b0;
			op_erase_r <= 1'b0;
		end else if (abort_evt || tm_done) begin
			wr_start_r <= 1'b0; // [R18]
		end else if (start_ok) begin
			wr_start_r <= 1'b1; // [R18]
			op_erase_r <= start_erase;
		end
	end

	// Read start: one-cycle EEPROM read, refused with program select set
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_start_r <= 1'b0;
		end else if (rd_start_r || abort_evt) begin
			rd_start_r <= 1'b0; // [R20]
		end else if (wr_mac) begin
			rd_start_r <= reg_wdata[PFTA_BIT_RD]
				&& !reg_wdata[PFTA_BIT_PGM]; // [R20]
		end
	end
	assign ee_rd_pulse = rd_start_r;

	// Write-done flag: completion wins over a software clear
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			done_flag_r <= 1'b0;
		end else if (tm_done) begin
			done_flag_r <= 1'b1; // [R19]
		end else if (wr_flags) begin
			done_flag_r <= reg_wdata[PFTA_BIT_DONE];
		end
	end

	// Array command issued in the cycle after an accepted start
	pfta_flash_cmd_t cmd_nxt;
	always_comb begin
		cmd_nxt = '0;
		cmd_nxt.space = start_space;
		cmd_nxt.prog = start_ok && !start_erase; // [R7]
		cmd_nxt.erase = start_ok && start_erase; // [R8]
		if (start_erase) begin
			cmd_nxt.addr = {ptr_r[PFTA_PTR_W-1:PFTA_ROW_LSB],
				PFTA_ROW_LSB'(0)}; // [R1] [R8]
		end else begin
			cmd_nxt.addr = {ptr_r[PFTA_PTR_W-1:PFTA_BLK_LSB],
				PFTA_BLK_LSB'(0)}; // [R1] [R7]
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cmd_r <= '0;
			wdata_r <= '0;
		end else begin
			cmd_r <= cmd_nxt;
			if (start_ok) begin
				wdata_r <= {hold_r[7], hold_r[6], hold_r[5], hold_r[4],
					hold_r[3], hold_r[2], hold_r[1], hold_r[0]}; // [R7]
			end
		end
	end
	assign fl_cmd = cmd_r;
	assign fl_wdata = wdata_r;
	assign fl_busy = tm_busy;

	// Fetch stalls for the whole self-timed cycle
	assign fetch_stall = tm_busy; // [R3] [R23]

	// Table instruction acceptance and pointer arithmetic on 21 bits
	logic take;
	logic [PFTA_PTR_W-1:0] ptr_inc, ptr_dec, acc_addr;
	assign tbl_ready = !tm_busy && !rd_pend_r; // [R3]
	assign take = tbl_req.valid && tbl_ready;
	assign ptr_inc = {ptr_r[PFTA_PTR_W-1],
		ptr_r[PFTA_PTR_LOW_W-1:0] + PFTA_PTR_LOW_W'(1)}; // [R12]
	assign ptr_dec = {ptr_r[PFTA_PTR_W-1],
		ptr_r[PFTA_PTR_LOW_W-1:0] - PFTA_PTR_LOW_W'(1)}; // [R12]
	assign acc_addr = (tbl_req.mode == PFTA_PTR_PRE_INC) ?
		ptr_inc : ptr_r; // [R11]

	// Pointer: byte writes from software win over table actions
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ptr_r <= '0;
		end else if (wr_pl || wr_ph || wr_pu) begin
			if (wr_pl) begin
				ptr_r[7:0] <= reg_wdata; // [R10]
			end
			if (wr_ph) begin
				ptr_r[15:8] <= reg_wdata; // [R10]
			end
			if (wr_pu) begin
				ptr_r[PFTA_PTR_W-1:16] <= reg_wdata[PFTA_UPPER_W-1:0];
			end
		end else if (take) begin
			unique case (tbl_req.mode)
				PFTA_PTR_KEEP: ptr_r <= ptr_r; // [R11]
				PFTA_PTR_POST_INC: ptr_r <= ptr_inc; // [R11]
				PFTA_PTR_POST_DEC: ptr_r <= ptr_dec; // [R11]
				PFTA_PTR_PRE_INC: ptr_r <= ptr_inc; // [R11]
			endcase
		end
	end

	// Table read: word fetch in the cycle after take, byte pick and latch load at the end of it
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			fr_en_r <= 1'b0;
			fr_addr_r <= '0;
			rd_pend_r <= 1'b0;
			rd_hi_r <= 1'b0;
		end else begin
			fr_en_r <= take && !tbl_req.write;
			rd_pend_r <= take && !tbl_req.write;
			if (take && !tbl_req.write) begin
				fr_addr_r <= acc_addr[PFTA_PTR_W-1:1]; // [R9]
				rd_hi_r <= acc_addr[0]; // [R24]
			end
		end
	end
	assign fr_en = fr_en_r;
	assign fr_word_addr = fr_addr_r;

	// Table latch: read return wins over a software write
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			latch_r <= '0;
		end else if (rd_pend_r) begin
			latch_r <= rd_hi_r ? fr_rdata[15:8] : fr_rdata[7:0]; // [R5] [R24]
		end else if (wr_latch) begin
			latch_r <= reg_wdata; // [R5]
		end
	end

	// Holding registers, one per low pointer code; the array is untouched
	genvar gi;
	generate
		for (gi = 0; gi < PFTA_HOLD_N; gi++) begin : g_hold
			always_ff @(posedge core_clk or negedge rst_n) begin
				if (!rst_n) begin
					hold_r[gi] <= '0;
				end else if (take && tbl_req.write
					&& acc_addr[PFTA_HOLD_IDX_W-1:0]
					== PFTA_HOLD_IDX_W'(gi)) begin
					hold_r[gi] <= latch_r; // [R6]
				end
			end
		end
	endgenerate

	// Register read mux; key port and unmapped offsets read zero
	logic [PFTA_DATA_W-1:0] rd_mux;
	assign rd_mux =
		hit(reg_addr, PFTA_OFF_MAC) ? {pgm_sel_r, cfg_sel_r, 1'b0,
			erase_en_r, abort_flag_r, wr_allow_r, wr_start_r, rd_start_r} :
		hit(reg_addr, PFTA_OFF_FLAGS2) ?
			(PFTA_DATA_W'(done_flag_r) << PFTA_BIT_DONE) :
		hit(reg_addr, PFTA_OFF_LATCH) ? latch_r :
		hit(reg_addr, PFTA_OFF_PTR_LOW) ? ptr_r[7:0] :
		hit(reg_addr, PFTA_OFF_PTR_HIGH) ? ptr_r[15:8] :
		hit(reg_addr, PFTA_OFF_PTR_UPPER) ?
			PFTA_DATA_W'(ptr_r[PFTA_PTR_W-1:16]) :
		'0; // [R13]

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_r <= '0;
		end else if (reg_rd) begin
			rdata_r <= rd_mux;
		end else begin
			rdata_r <= '0;
		end
	end
	assign reg_rdata = rdata_r;

	// Undecodable fetched words become no-operations
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			exec_r <= PFTA_NOP_WORD;
		end else begin
			exec_r <= fetch_illegal ? PFTA_NOP_WORD : fetch_word; // [R4]
		end
	end
	assign exec_word = exec_r;

	// Word alignment of code written by software is the caller's duty [R21]
endmodule
`default_nettype wire

// file: pkg/pfta_pkg.sv
// Purpose: Shared constants and types for program flash table access.
// Assumes: Core clock of 10 MHz; 12-bit special register addresses.
// Notes: Key and flag offsets sit near the control register; latch and pointer sit higher at FF5h-FF8h.
package pfta_pkg;

	// Register port geometry
	localparam int PFTA_ADDR_W = 12;
	localparam int PFTA_DATA_W = 8;

	// Register offsets
	localparam logic [11:0] PFTA_OFF_MAC = 12'hFA6;
	localparam logic [11:0] PFTA_OFF_KEY = 12'hFA7;
	localparam logic [11:0] PFTA_OFF_FLAGS2 = 12'hFA1;
	localparam logic [11:0] PFTA_OFF_LATCH = 12'hFF5;
	localparam logic [11:0] PFTA_OFF_PTR_LOW = 12'hFF6;
	localparam logic [11:0] PFTA_OFF_PTR_HIGH = 12'hFF7;
	localparam logic [11:0] PFTA_OFF_PTR_UPPER = 12'hFF8;

	// Control register bit positions
	localparam int PFTA_BIT_PGM = 7;
	localparam int PFTA_BIT_CFG = 6;
	localparam int PFTA_BIT_ERASE = 4;
	localparam int PFTA_BIT_ABORT = 3;
	localparam int PFTA_BIT_ALLOW = 2;
	localparam int PFTA_BIT_WR = 1;
	localparam int PFTA_BIT_RD = 0;

	// Write-done flag position in the second peripheral flag register
	localparam int PFTA_BIT_DONE = 4;

	// Unlock keys
	localparam logic [7:0] PFTA_KEY_FIRST = 8'h55;
	localparam logic [7:0] PFTA_KEY_SECOND = 8'hAA;

	// Pointer and block geometry
	localparam int PFTA_PTR_W = 22;
	localparam int PFTA_PTR_LOW_W = 21;
	localparam int PFTA_UPPER_W = 6;
	localparam int PFTA_HOLD_N = 8;
	localparam int PFTA_HOLD_IDX_W = 3;
	localparam int PFTA_BLK_LSB = 3;
	localparam int PFTA_ROW_LSB = 6;
	localparam int PFTA_WORD_ADDR_W = 21;

	// Self-timed cycle length
	localparam int PFTA_PROG_TIME_US = 2000;
	localparam int PFTA_CLK_KHZ = 10000;
	localparam int PFTA_PROG_CYCLES = PFTA_PROG_TIME_US * PFTA_CLK_KHZ / 1000;

	// Word executed in place of an undecodable fetch
	localparam logic [15:0] PFTA_NOP_WORD = 16'h0000;

	// Table pointer action requested by a table instruction
	typedef enum logic [1:0] {
		PFTA_PTR_KEEP,
		PFTA_PTR_POST_INC,
		PFTA_PTR_POST_DEC,
		PFTA_PTR_PRE_INC
	} pfta_ptr_mode_t;

	// Target memory space
	typedef enum logic [1:0] {
		PFTA_SPACE_EEPROM,
		PFTA_SPACE_PROGRAM,
		PFTA_SPACE_CONFIG
	} pfta_space_t;

	// Unlock sequence progress
	typedef enum logic [1:0] {
		PFTA_UNLK_IDLE,
		PFTA_UNLK_HALF,
		PFTA_UNLK_ARMED
	} pfta_unlock_t;

	// Table instruction from the core
	typedef struct packed {
		logic valid;
		logic write;
		pfta_ptr_mode_t mode;
	} pfta_tbl_req_t;

	// Self-timed command to the array
	typedef struct packed {
		logic prog;
		logic erase;
		pfta_space_t space;
		logic [21:0] addr;
	} pfta_flash_cmd_t;

endpackage

// file: tb/pfta_flash_model.sv
// Purpose: Flash array model answering word reads.
// Assumes: A word is asked for by a one-cycle fr_en.
// Notes: Outside an answer the bus toggles so stale data cannot match.
`timescale 1ns/1ps
`default_nettype none
module pfta_flash_model (
	input wire logic core_clk,
	input wire logic fr_en,
	input wire logic [20:0] fr_word_addr,
	output logic [15:0] fr_rdata
);
	// Low byte depends on address and space bit, high byte inverted
	wire logic [7:0] lo_b = fr_word_addr[7:0] ^ {fr_word_addr[20], 7'h00};
	logic [15:0] last_r = 16'h5AA5;
	// Word while the request stands, since the latch takes it at that edge
	assign fr_rdata = fr_en ? {~lo_b, lo_b} : ~last_r;
	// Remembers the last value so the idle bus shows its inverse
	always @(posedge core_clk)
		last_r <= fr_rdata;
endmodule
`default_nettype wire

// file: tb/pfta_top_props.sv
// Purpose: Port-level checks for the flash table access block.
// Assumes: One clock domain; rst_n low clears everything.
// Notes: Reset events abort a cycle, so the length check skips them.
`timescale 1ns/1ps
`default_nettype none
module pfta_top_props
	import pfta_pkg::*;
#(
	parameter int unsigned PROG_CYCLES = PFTA_PROG_CYCLES
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic [PFTA_ADDR_W-1:0] reg_addr,
	input wire logic [PFTA_DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [PFTA_DATA_W-1:0] reg_rdata,
	input wire pfta_tbl_req_t tbl_req,
	input wire logic tbl_ready,
	input wire logic fr_en,
	input wire pfta_flash_cmd_t fl_cmd,
	input wire logic fl_busy,
	input wire logic ee_rd_pulse,
	input wire logic ext_reset_evt,
	input wire logic wdt_reset_evt,
	input wire logic fetch_stall,
	input wire logic [15:0] fetch_word,
	input wire logic fetch_illegal,
	input wire logic [15:0] exec_word
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	// Decoded control writes and command pulse
	wire logic mac_wr = reg_wr && reg_addr == PFTA_OFF_MAC;
	wire logic start_wr = mac_wr && reg_wdata[PFTA_BIT_WR];
	wire logic ee_wr = mac_wr && reg_wdata[PFTA_BIT_RD] && !reg_wdata[7];
	wire logic fl_go = fl_cmd.prog || fl_cmd.erase;
	logic [31:0] busy_cnt_r;
	// Counts consecutive busy cycles
	always_ff @(posedge core_clk or negedge rst_n)
		if (!rst_n)
			busy_cnt_r <= 32'h0;
		else
			busy_cnt_r <= fl_busy ? busy_cnt_r + 32'h1 : 32'h0;
	sequence s_tbl_read;
		tbl_req.valid && tbl_ready && !tbl_req.write;
	endsequence
	sequence s_word_fetch;
		fr_en && !tbl_ready;
	endsequence
	a_read_fetch: assert property (s_tbl_read |=> s_word_fetch)
		else $error("table read gave no word fetch");
	a_stall_busy: assert property (fetch_stall == fl_busy)
		else $error("fetch stall differs from busy");
	a_busy_start: assert property ($rose(fl_busy) |-> fl_go)
		else $error("busy rose without a command");
	a_cmd_cause: assert property (fl_go |-> $past(start_wr))
		else $error("command without a start write");
	a_prog_align: assert property (fl_cmd.prog |-> fl_cmd.addr[2:0] == 3'h0
		&& !fl_cmd.erase) else $error("program block not aligned");
	a_erase_row: assert property (fl_cmd.erase |-> fl_cmd.addr[5:0] == 6'h00
		&& fl_cmd.space != PFTA_SPACE_EEPROM) else $error("erase row wrong");
	a_busy_len: assert property ($fell(fl_busy)
		&& !$past(ext_reset_evt || wdt_reset_evt) |-> busy_cnt_r == PROG_CYCLES)
		else $error("self-timed cycle length wrong");
	a_exec_nop: assert property (1'b1 |=> exec_word ==
		($past(fetch_illegal) ? PFTA_NOP_WORD : $past(fetch_word)))
		else $error("executed word wrong");
	a_key_zero: assert property (reg_rd && reg_addr == PFTA_OFF_KEY
		|=> reg_rdata == 8'h00) else $error("key port read not zero");
	a_ee_cause: assert property (ee_rd_pulse |-> $past(ee_wr))
		else $error("eeprom read without a read start");
	a_ee_single: assert property (ee_rd_pulse |=> !ee_rd_pulse)
		else $error("eeprom read pulse too long");
endmodule
`default_nettype wire

// file: tb/pfta_top_tb_top.sv
// Purpose: Self-checking bench for the flash table access block.
// Assumes: Short self-timed cycle of PC clocks.
// Notes: A monitor records command pulses, busy length and read pulses.
`timescale 1ns/1ps
`default_nettype none
module pfta_top_tb_top
	import pfta_pkg::*;
;
	localparam int unsigned PC = 20;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [11:0] reg_addr = 12'h000;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [15:0] fetch_word = 16'h0000;
	logic fetch_illegal = 1'b0;
	logic ext_reset_evt = 1'b0;
	logic wdt_reset_evt = 1'b0;
	pfta_tbl_req_t tbl_req = '0;
	logic [7:0] reg_rdata;
	logic tbl_ready, fr_en, fl_busy, ee_rd_pulse, fetch_stall;
	logic [20:0] fr_word_addr;
	logic [15:0] fr_rdata, exec_word;
	pfta_flash_cmd_t fl_cmd, cmd_seen;
	logic [63:0] fl_wdata, wdata_seen;
	int errors = 0;
	int checks = 0;
	int cmds = 0;
	int ees = 0;
	int busy_n = 0;
	int cyc = 0;
	always #50 core_clk = ~core_clk;
	pfta_top #(.PROG_CYCLES(PC)) uut (.core_clk(core_clk), .rst_n(rst_n),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .tbl_req(tbl_req),
		.tbl_ready(tbl_ready), .fr_en(fr_en), .fr_word_addr(fr_word_addr),
		.fr_rdata(fr_rdata), .fl_cmd(fl_cmd), .fl_wdata(fl_wdata),
		.fl_busy(fl_busy), .ee_rd_pulse(ee_rd_pulse),
		.ext_reset_evt(ext_reset_evt), .wdt_reset_evt(wdt_reset_evt),
		.fetch_stall(fetch_stall), .fetch_word(fetch_word),
		.fetch_illegal(fetch_illegal), .exec_word(exec_word));
	pfta_flash_model u_flash (.core_clk(core_clk), .fr_en(fr_en),
		.fr_word_addr(fr_word_addr), .fr_rdata(fr_rdata));
	// Records commands, stalled busy cycles and eeprom reads
	always @(posedge core_clk) begin
		if (fl_cmd.prog || fl_cmd.erase) begin
			cmd_seen <= fl_cmd;
			wdata_seen <= fl_wdata;
			cmds <= cmds + 1;
		end
		if (fl_busy && fetch_stall)
			busy_n <= busy_n + 1;
		if (ee_rd_pulse)
			ees <= ees + 1;
	end
	task automatic end_of_test();
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		checks++;
		if (seen !== exp) begin
			errors++;
			$display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask
	// Register port master
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic mchk(input logic [11:0] a, input logic [7:0] m,
		input logic [7:0] e);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata & m, e);
	endtask
	task automatic tbl(input logic w, input pfta_ptr_mode_t m);
		@(posedge core_clk);
		tbl_req <= '{valid: 1'b1, write: w, mode: m};
		@(posedge core_clk);
		tbl_req <= '0;
		repeat (w ? 0 : 2) @(posedge core_clk);
	endtask
	task automatic setp(input logic [21:0] p);
		wr(PFTA_OFF_PTR_UPPER, {2'b00, p[21:16]});
		wr(PFTA_OFF_PTR_HIGH, p[15:8]);
		wr(PFTA_OFF_PTR_LOW, p[7:0]);
	endtask
	task automatic arm(input logic [7:0] mac);
		wr(PFTA_OFF_MAC, mac);
		wr(PFTA_OFF_KEY, PFTA_KEY_FIRST);
		wr(PFTA_OFF_KEY, PFTA_KEY_SECOND);
		busy_n = 0;
		wr(PFTA_OFF_MAC, mac | 8'h02);
	endtask
	task automatic go(input logic [7:0] mac);
		arm(mac);
		repeat (PC + 3) @(posedge core_clk);
	endtask
	task automatic t_reset();
		mchk(PFTA_OFF_MAC, 8'h37, 8'h00);
		wr(PFTA_OFF_KEY, PFTA_KEY_FIRST);
		mchk(PFTA_OFF_KEY, 8'hFF, 8'h00);
		mchk(12'h123, 8'hFF, 8'h00);
		$display("test reset values done");
	endtask
	// Pointer actions with wrap in the low 21 bits
	task automatic t_read();
		pfta_ptr_mode_t ml[5];
		logic [21:0] p, a;
		logic [7:0] lo;
		ml = '{PFTA_PTR_POST_INC, PFTA_PTR_POST_INC, PFTA_PTR_PRE_INC,
			PFTA_PTR_POST_DEC, PFTA_PTR_KEEP};
		p = 22'h3FFFFE;
		setp(p);
		for (int i = 0; i < 5; i++) begin
			a = (ml[i] == PFTA_PTR_PRE_INC) ? {p[21], p[20:0] + 21'h1} : p;
			tbl(1'b0, ml[i]);
			lo = a[8:1] ^ {a[21], 7'h00};
			mchk(PFTA_OFF_LATCH, 8'hFF, a[0] ? ~lo : lo);
			if (ml[i] == PFTA_PTR_POST_DEC)
				p = {p[21], p[20:0] - 21'h1};
			else if (ml[i] != PFTA_PTR_KEEP)
				p = {p[21], p[20:0] + 21'h1};
			mchk(PFTA_OFF_PTR_UPPER, 8'hFF, {2'b00, p[21:16]});
			mchk(PFTA_OFF_PTR_LOW, 8'hFF, p[7:0]);
		end
		$display("test table read done");
	endtask
	task automatic t_prog();
		int n;
		n = cmds;
		setp(22'h000105); // Program block, mid-block start; the holding index wraps
		for (int i = 0; i < 8; i++) begin
			wr(PFTA_OFF_LATCH, 8'h10 + i[7:0]);
			tbl(1'b1, PFTA_PTR_POST_INC);
		end
		chk(cmds, n);
		go(8'h84);
		chk(cmds, n + 1);
		chk(cmd_seen, {2'b10, PFTA_SPACE_PROGRAM, 22'h000108});
		chk(wdata_seen, 64'h1211101716151413);
		chk(busy_n, PC);
		mchk(PFTA_OFF_MAC, 8'hF7, 8'h84);
		mchk(PFTA_OFF_FLAGS2, 8'h10, 8'h10);
		mchk(PFTA_OFF_FLAGS2, 8'h10, 8'h10);
		wr(PFTA_OFF_FLAGS2, 8'h00);
		mchk(PFTA_OFF_FLAGS2, 8'h10, 8'h00);
		$display("test block program done");
	endtask
	task automatic t_refuse();
		int n;
		n = cmds;
		wr(PFTA_OFF_MAC, 8'h86);
		wr(PFTA_OFF_KEY, PFTA_KEY_SECOND);
		wr(PFTA_OFF_KEY, PFTA_KEY_FIRST);
		wr(PFTA_OFF_MAC, 8'h86);
		wr(PFTA_OFF_KEY, PFTA_KEY_FIRST);
		wr(PFTA_OFF_LATCH, 8'h00);
		wr(PFTA_OFF_KEY, PFTA_KEY_SECOND);
		wr(PFTA_OFF_MAC, 8'h86);
		arm(8'h80);
		repeat (2) @(posedge core_clk);
		chk(cmds, n);
		mchk(PFTA_OFF_MAC, 8'h02, 8'h00);
		$display("test refused starts done");
	endtask
	task automatic t_erase();
		int n;
		setp(22'h00017F);
		n = cmds;
		go(8'h94);
		chk(cmds, n + 1);
		chk(cmd_seen, {2'b01, PFTA_SPACE_PROGRAM, 22'h000140});
		mchk(PFTA_OFF_MAC, 8'h16, 8'h04);
		$display("test row erase done");
	endtask
	task automatic t_spaces();
		logic [7:0] macs[3];
		pfta_space_t sps[3];
		macs = '{8'h04, 8'hC4, 8'h44};
		sps = '{PFTA_SPACE_EEPROM, PFTA_SPACE_CONFIG, PFTA_SPACE_CONFIG};
		setp(22'h00000B);
		for (int i = 0; i < 3; i++) begin
			go(macs[i]);
			chk(cmd_seen, {2'b10, sps[i], 22'h000008});
		end
		$display("test space select done");
	endtask
	task automatic t_abort();
		logic [7:0] mac;
		for (int e = 0; e < 2; e++) begin
			mac = e ? 8'hC4 : 8'h84;
			arm(mac);
			repeat (5) @(posedge core_clk);
			ext_reset_evt <= (e == 0);
			wdt_reset_evt <= (e == 1);
			@(posedge core_clk);
			ext_reset_evt <= 1'b0;
			wdt_reset_evt <= 1'b0;
			@(posedge core_clk);
			#1 chk(fl_busy, 1'b0);
			mchk(PFTA_OFF_MAC, 8'hCF, (mac & 8'hC0) | 8'h08);
		end
		$display("test reset abort done");
	endtask
	task automatic t_ee();
		int n;
		n = ees;
		wr(PFTA_OFF_MAC, 8'h01);
		wr(PFTA_OFF_MAC, 8'h81);
		repeat (2) @(posedge core_clk);
		chk(ees, n + 1);
		mchk(PFTA_OFF_MAC, 8'h01, 8'h00);
		$display("test eeprom read done");
	endtask
	task automatic t_fetch();
		@(posedge core_clk);
		fetch_word <= 16'hA55A;
		@(posedge core_clk);
		#1 chk(exec_word, 16'hA55A);
		@(posedge core_clk);
		fetch_illegal <= 1'b1;
		@(posedge core_clk);
		#1 chk(exec_word, PFTA_NOP_WORD);
		$display("test fetch done");
	endtask
	initial begin
		repeat (4) @(posedge core_clk);
		rst_n <= 1'b1;
		t_reset();
		t_read();
		t_prog();
		t_refuse();
		t_erase();
		t_spaces();
		t_abort();
		t_ee();
		t_fetch();
		end_of_test();
	end
	// Cuts a hang short
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 6000) begin
			errors = errors + 1;
			end_of_test();
		end
	end
endmodule
bind pfta_top pfta_top_props #(.PROG_CYCLES(PROG_CYCLES)) u_props (
	.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .tbl_req(tbl_req), .tbl_ready(tbl_ready),
	.fr_en(fr_en), .fl_cmd(fl_cmd), .fl_busy(fl_busy),
	.ee_rd_pulse(ee_rd_pulse), .ext_reset_evt(ext_reset_evt),
	.wdt_reset_evt(wdt_reset_evt), .fetch_stall(fetch_stall),
	.fetch_word(fetch_word), .fetch_illegal(fetch_illegal),
	.exec_word(exec_word));
`default_nettype wire
